/* File: adcseq_defines.svh */
`ifndef ADCSEQ_DEFINES_SVH
`define ADCSEQ_DEFINES_SVH

// register byte offsets
`define ADCSEQ_OFS_MODE_CONTROL   5'h00
`define ADCSEQ_OFS_ACCUM_CONTROL  5'h01
`define ADCSEQ_OFS_WINDOW_CONTROL 5'h04
`define ADCSEQ_OFS_SAMPLE_LENGTH  5'h05
`define ADCSEQ_OFS_INPUT_SELECT   5'h06
`define ADCSEQ_OFS_COMMAND        5'h08
`define ADCSEQ_OFS_EVENT_CONTROL  5'h09
`define ADCSEQ_OFS_INT_ENABLE     5'h0A
`define ADCSEQ_OFS_INT_FLAGS      5'h0B
`define ADCSEQ_OFS_DEBUG_CONTROL  5'h0C
`define ADCSEQ_OFS_STAGING        5'h0D
`define ADCSEQ_OFS_RESULT         5'h10
`define ADCSEQ_OFS_LOW_THRESHOLD  5'h12
`define ADCSEQ_OFS_HIGH_THRESHOLD 5'h14
`define ADCSEQ_OFS_HIGH_BYTE      5'h01

// field positions
`define ADCSEQ_BIT_CONTINUOUS     1
`define ADCSEQ_BIT_START          0
`define ADCSEQ_BIT_EVENT_START    0
`define ADCSEQ_BIT_WINDOW_MATCH   1
`define ADCSEQ_BIT_RESULT_READY   0
`define ADCSEQ_BIT_RUN_IN_DEBUG   0

// reset values
`define ADCSEQ_RST_BYTE           8'h00
`define ADCSEQ_RST_WORD           16'h0000
`define ADCSEQ_RST_SELECT         5'h00

// timing and limits
`define ADCSEQ_BASE_SAMPLE_CYCLES 6'h02
`define ADCSEQ_RAW_MAX            10'h3FF
`define ADCSEQ_RAW_MIN            10'h000

`endif

/* File: adcseq_pkg.sv */
package adcseq_pkg;

	typedef enum logic [1:0] {
		ADCSEQ_IDLE,
		ADCSEQ_SAMPLE,
		ADCSEQ_CONVERT
	} adcseq_state_type;

	typedef enum logic [2:0] {
		ADCSEQ_WIN_NONE    = 3'h0,
		ADCSEQ_WIN_BELOW   = 3'h1,
		ADCSEQ_WIN_ABOVE   = 3'h2,
		ADCSEQ_WIN_INSIDE  = 3'h3,
		ADCSEQ_WIN_OUTSIDE = 3'h4
	} adcseq_window_type;

endpackage

/* File: adcseq_regs.sv */
// Function
// R1 - sampling lasts two converter cycles plus the five-bit sample extension
// R2 - input select codes 0x00-0x0B pins, 0x1C-0x1F internal sources
// R3 - input select change during conversion applies after it finishes
// R4 - writing start bit one launches a conversion, first of continuous sequence
// R5 - start bit reads one while converting, clears itself on completion
// R6 - writing start bit zero during conversion aborts it
// R7 - with event start enable set, an event starts a conversion
// R8 - interrupt enable bit 1 window match, bit 0 result ready
// R9 - at measurement end, window compare sets window match flag bit 1
// R10 - result ready flag bit 0 sets when a measurement completes
// R11 - flags clear by writing one or reading result; zero writes ignored
// R12 - run in debug zero halts block and ignores events in debug break
// R13 - one shared staging byte serves all sixteen-bit registers, also accessible
// R14 - sixteen-bit registers: low byte at base, high byte at base plus one
// R15 - raw value saturates at 0x3FF above reference, 0x000 below zero
// R16 - accumulated result never exceeds 0xFFC0 with 64 samples
// R17 - result is a sixteen-bit unsigned value at offset 0x10
// R18 - window compare uses final accumulated sum; low threshold at 0x12
// R19 - window mode codes none, below, above, inside, outside
// R20 - accumulation count codes 0-6 select 1 to 64 samples
// R21 - continuous mode restarts conversion immediately after each completion
// R22 - each interrupt request asserts while its flag and enable are set
// R23 - accepted event behaves like a software write of one to start
//
// The address-and-strobe port was left to the implementer.
`include "adcseq_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module adcseq_regs (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	// register port
	input  wire logic [4:0]  reg_addr,
	input  wire logic [7:0]  reg_wr_data,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rd_data,
	// system
	input  wire logic        start_event,
	input  wire logic        debug_break,
	// converter core
	output logic      [4:0]  input_select,
	output logic             sample_active,
	output logic             convert_active,
	input  wire logic        core_done,
	input  wire logic [9:0]  core_data,
	input  wire logic        core_over,
	input  wire logic        core_under,
	// interrupt requests
	output logic             result_ready_irq,
	output logic             window_match_irq
);

	adcseq_pkg::adcseq_state_type state_q;

	logic [4:0]  sample_extension_q;
	logic [4:0]  input_select_q;
	logic [4:0]  input_select_active_q;
	logic        continuous_mode_q;
	logic [2:0]  accumulation_count_q;
	logic [2:0]  window_mode_q;
	logic        event_start_enable_q;
	logic [1:0]  int_enable_q;
	logic [1:0]  int_flags_q;
	logic        run_in_debug_q;
	logic [7:0]  staging_q;
	logic [15:0] conversion_result_q;
	logic [15:0] low_threshold_q;
	logic [15:0] high_threshold_q;
	logic [15:0] accum_q;
	logic [6:0]  samples_q;
	logic [5:0]  phase_q;
	logic [7:0]  rd_data_q;

	logic        halted;
	logic        wr_start_one;
	logic        wr_start_zero;
	logic        launch;
	logic        sample_last;
	logic        accum_last;
	logic        finish;
	logic [9:0]  raw_sat;
	logic [15:0] accum_sum;
	logic        read_result;
	logic        result_ready_set;
	logic        window_match_set;

	// number of samples summed into one result
	function automatic logic [6:0] sample_target(input logic [2:0] code);
		logic [6:0] n;
		n = 7'h01;
		if (code <= 3'h6) begin // R20
			n = 7'(7'h01 << code);
		end
		return n;
	endfunction

	// window condition on the finished sum
	function automatic logic window_hit(
		input logic [2:0]  mode,
		input logic [15:0] value,
		input logic [15:0] low,
		input logic [15:0] high
	);
		logic hit;
		hit = 1'b0;
		case (mode) // R19
			3'h1: hit = value < low;
			3'h2: hit = value > high;
			3'h3: hit = (value > low) && (value < high);
			3'h4: hit = (value < low) || (value > high);
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	// write to the high byte of a sixteen-bit register
	function automatic logic wr_high(input logic [4:0] base, input logic [4:0] addr);
		return addr == 5'(base + `ADCSEQ_OFS_HIGH_BYTE);
	endfunction

	assign halted = debug_break && !run_in_debug_q; // R12

	assign wr_start_one = reg_wr && reg_addr == `ADCSEQ_OFS_COMMAND
		&& reg_wr_data[`ADCSEQ_BIT_START];
	assign wr_start_zero = reg_wr && reg_addr == `ADCSEQ_OFS_COMMAND
		&& !reg_wr_data[`ADCSEQ_BIT_START];

	// software start or an accepted event
	assign launch = state_q == adcseq_pkg::ADCSEQ_IDLE && !halted // R12
		&& (wr_start_one || (event_start_enable_q && start_event)); // R4 R7 R23

	assign sample_last = phase_q == 6'(6'(sample_extension_q) + `ADCSEQ_BASE_SAMPLE_CYCLES
		- 6'h01); // R1

	always_comb begin
		raw_sat = core_data;
		if (core_over) begin // R15
			raw_sat = `ADCSEQ_RAW_MAX;
		end else if (core_under) begin
			raw_sat = `ADCSEQ_RAW_MIN;
		end
	end

	// at most 64 x 0x3FF = 0xFFC0, so sixteen bits never wrap
	assign accum_sum = accum_q + 16'(raw_sat); // R16
	assign accum_last = samples_q == sample_target(accumulation_count_q) - 7'h01;
	assign finish = state_q == adcseq_pkg::ADCSEQ_CONVERT && !halted && core_done
		&& accum_last;

	assign read_result = reg_rd && reg_addr == `ADCSEQ_OFS_RESULT;
	assign result_ready_set = finish; // R10
	assign window_match_set = finish
		&& window_hit(window_mode_q, accum_sum, low_threshold_q, high_threshold_q); // R9 R18

	// conversion sequencer
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q   <= adcseq_pkg::ADCSEQ_IDLE;
			phase_q   <= 6'h00;
			samples_q <= 7'h00;
			accum_q   <= `ADCSEQ_RST_WORD;
		end else if (wr_start_zero && state_q != adcseq_pkg::ADCSEQ_IDLE) begin
			state_q   <= adcseq_pkg::ADCSEQ_IDLE; // R6
			phase_q   <= 6'h00;
			samples_q <= 7'h00;
			accum_q   <= `ADCSEQ_RST_WORD;
		end else if (!halted) begin // R12
			unique case (state_q)
				adcseq_pkg::ADCSEQ_IDLE: begin
					if (launch) begin
						state_q   <= adcseq_pkg::ADCSEQ_SAMPLE;
						phase_q   <= 6'h00;
						samples_q <= 7'h00;
						accum_q   <= `ADCSEQ_RST_WORD;
					end
				end
				adcseq_pkg::ADCSEQ_SAMPLE: begin
					if (sample_last) begin
						state_q <= adcseq_pkg::ADCSEQ_CONVERT; // R1
						phase_q <= 6'h00;
					end else begin
						phase_q <= phase_q + 6'h01;
					end
				end
				adcseq_pkg::ADCSEQ_CONVERT: begin
					if (core_done) begin
						state_q <= adcseq_pkg::ADCSEQ_SAMPLE;
						if (accum_last) begin
							samples_q <= 7'h00;
							accum_q   <= `ADCSEQ_RST_WORD;
							if (!continuous_mode_q) begin
								state_q <= adcseq_pkg::ADCSEQ_IDLE; // R5
							end // else R21
						end else begin
							samples_q <= samples_q + 7'h01;
							accum_q   <= accum_sum;
						end
					end
				end
			endcase
		end
	end

	// finished result
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			conversion_result_q <= `ADCSEQ_RST_WORD;
		end else if (finish) begin
			conversion_result_q <= accum_sum; // R17
		end
	end

	// multiplexer select follows the register only between conversions
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			input_select_active_q <= `ADCSEQ_RST_SELECT;
		end else if (state_q == adcseq_pkg::ADCSEQ_IDLE || finish) begin
			input_select_active_q <= input_select_q; // R2 R3
		end
	end

	// control registers
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			continuous_mode_q    <= 1'b0;
			accumulation_count_q <= 3'h0;
			window_mode_q        <= 3'h0;
			sample_extension_q   <= 5'h00;
			input_select_q       <= `ADCSEQ_RST_SELECT;
			event_start_enable_q <= 1'b0;
			int_enable_q         <= 2'h0;
			run_in_debug_q       <= 1'b0;
		end else if (reg_wr) begin
			unique case (reg_addr)
				`ADCSEQ_OFS_MODE_CONTROL: begin
					continuous_mode_q <= reg_wr_data[`ADCSEQ_BIT_CONTINUOUS];
				end
				`ADCSEQ_OFS_ACCUM_CONTROL: begin
					accumulation_count_q <= reg_wr_data[2:0]; // R20
				end
				`ADCSEQ_OFS_WINDOW_CONTROL: begin
					window_mode_q <= reg_wr_data[2:0]; // R19
				end
				`ADCSEQ_OFS_SAMPLE_LENGTH: begin
					sample_extension_q <= reg_wr_data[4:0]; // R1
				end
				`ADCSEQ_OFS_INPUT_SELECT: begin
					input_select_q <= reg_wr_data[4:0]; // R2
				end
				`ADCSEQ_OFS_EVENT_CONTROL: begin
					event_start_enable_q <= reg_wr_data[`ADCSEQ_BIT_EVENT_START]; // R7
				end
				`ADCSEQ_OFS_INT_ENABLE: begin
					int_enable_q <= reg_wr_data[1:0]; // R8
				end
				`ADCSEQ_OFS_DEBUG_CONTROL: begin
					run_in_debug_q <= reg_wr_data[`ADCSEQ_BIT_RUN_IN_DEBUG]; // R12
				end
				default: begin
				end
			endcase
		end
	end

	// sixteen-bit thresholds, committed on the high byte write
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			low_threshold_q  <= `ADCSEQ_RST_WORD;
			high_threshold_q <= `ADCSEQ_RST_WORD;
		end else if (reg_wr && wr_high(`ADCSEQ_OFS_LOW_THRESHOLD, reg_addr)) begin
			low_threshold_q <= {reg_wr_data, staging_q}; // R13 R14 R18
		end else if (reg_wr && wr_high(`ADCSEQ_OFS_HIGH_THRESHOLD, reg_addr)) begin
			high_threshold_q <= {reg_wr_data, staging_q}; // R13 R14
		end
	end

	// shared staging byte
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			staging_q <= `ADCSEQ_RST_BYTE;
		end else if (reg_wr && (reg_addr == `ADCSEQ_OFS_STAGING
			|| reg_addr == `ADCSEQ_OFS_LOW_THRESHOLD
			|| reg_addr == `ADCSEQ_OFS_HIGH_THRESHOLD)) begin
			staging_q <= reg_wr_data; // R13
		end else if (reg_rd) begin
			unique case (reg_addr)
				`ADCSEQ_OFS_RESULT:         staging_q <= conversion_result_q[15:8]; // R14
				`ADCSEQ_OFS_LOW_THRESHOLD:  staging_q <= low_threshold_q[15:8];
				`ADCSEQ_OFS_HIGH_THRESHOLD: staging_q <= high_threshold_q[15:8];
				default: begin
				end
			endcase
		end
	end

	// interrupt flags: hardware set wins over any clear
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			int_flags_q <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == `ADCSEQ_BIT_RESULT_READY && result_ready_set)
					|| (i == `ADCSEQ_BIT_WINDOW_MATCH && window_match_set)) begin
					int_flags_q[i] <= 1'b1; // R9 R10
				end else if (read_result
					|| (reg_wr && reg_addr == `ADCSEQ_OFS_INT_FLAGS && reg_wr_data[i])) begin
					int_flags_q[i] <= 1'b0; // R11
				end
			end
		end
	end

	// read data, one cycle after the strobe
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_data_q <= `ADCSEQ_RST_BYTE;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`ADCSEQ_OFS_MODE_CONTROL:   rd_data_q <= {6'h00, continuous_mode_q, 1'b0};
				`ADCSEQ_OFS_ACCUM_CONTROL:  rd_data_q <= {5'h00, accumulation_count_q};
				`ADCSEQ_OFS_WINDOW_CONTROL: rd_data_q <= {5'h00, window_mode_q};
				`ADCSEQ_OFS_SAMPLE_LENGTH:  rd_data_q <= {3'h0, sample_extension_q};
				`ADCSEQ_OFS_INPUT_SELECT:   rd_data_q <= {3'h0, input_select_q};
				`ADCSEQ_OFS_COMMAND: begin
					rd_data_q <= {7'h00, state_q != adcseq_pkg::ADCSEQ_IDLE}; // R5
				end
				`ADCSEQ_OFS_EVENT_CONTROL:  rd_data_q <= {7'h00, event_start_enable_q};
				`ADCSEQ_OFS_INT_ENABLE:     rd_data_q <= {6'h00, int_enable_q};
				`ADCSEQ_OFS_INT_FLAGS:      rd_data_q <= {6'h00, int_flags_q};
				`ADCSEQ_OFS_DEBUG_CONTROL:  rd_data_q <= {7'h00, run_in_debug_q};
				`ADCSEQ_OFS_STAGING:        rd_data_q <= staging_q; // R13
				`ADCSEQ_OFS_RESULT:         rd_data_q <= conversion_result_q[7:0]; // R14
				`ADCSEQ_OFS_LOW_THRESHOLD:  rd_data_q <= low_threshold_q[7:0];
				`ADCSEQ_OFS_HIGH_THRESHOLD: rd_data_q <= high_threshold_q[7:0];
				5'(`ADCSEQ_OFS_RESULT + `ADCSEQ_OFS_HIGH_BYTE),
				5'(`ADCSEQ_OFS_LOW_THRESHOLD + `ADCSEQ_OFS_HIGH_BYTE),
				5'(`ADCSEQ_OFS_HIGH_THRESHOLD + `ADCSEQ_OFS_HIGH_BYTE): begin
					rd_data_q <= staging_q; // R13 R14
				end
				default: rd_data_q <= `ADCSEQ_RST_BYTE;
			endcase
		end
	end

	assign reg_rd_data    = rd_data_q;
	assign input_select   = input_select_active_q;
	assign sample_active  = state_q == adcseq_pkg::ADCSEQ_SAMPLE;
	assign convert_active = state_q == adcseq_pkg::ADCSEQ_CONVERT;

	assign result_ready_irq = int_flags_q[`ADCSEQ_BIT_RESULT_READY]
		&& int_enable_q[`ADCSEQ_BIT_RESULT_READY]; // R22
	assign window_match_irq = int_flags_q[`ADCSEQ_BIT_WINDOW_MATCH]
		&& int_enable_q[`ADCSEQ_BIT_WINDOW_MATCH]; // R22

endmodule

`default_nettype wire

/* File: adcseq_regs_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module adcseq_regs_monitor (
	// clock and reset
	input wire logic       sys_clk,
	input wire logic       reset_n,
	// register port
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wr_data,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	// system and core
	input wire logic       start_event,
	input wire logic       debug_break,
	input wire logic [4:0] input_select,
	input wire logic       sample_active,
	input wire logic       convert_active,
	input wire logic       core_done,
	// interrupt requests
	input wire logic       result_ready_irq,
	input wire logic       window_match_irq
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	logic busy;
	assign busy = sample_active || convert_active;
	chk_start_launch: assert property (
		reg_wr && reg_addr == 5'h08 && reg_wr_data[0] && !busy && !debug_break |=> sample_active)
		else $error("start write ignored");
	chk_abort_stop: assert property (
		reg_wr && reg_addr == 5'h08 && !reg_wr_data[0] && busy && !debug_break |=> !busy)
		else $error("stop write ignored");
	chk_sample_min: assert property (
		$rose(sample_active) && !reg_wr |=> sample_active)
		else $error("sampling under two cycles");
	chk_convert_after: assert property (
		$rose(convert_active) |-> $past(sample_active))
		else $error("convert without sampling");
	chk_launch_cause: assert property (
		$rose(sample_active) |-> $past(reg_wr) || $past(start_event) || $past(core_done)
			|| $past(core_done, 2))
		else $error("sampling without cause");
	chk_ready_cause: assert property (
		$rose(result_ready_irq) |-> $past(core_done && convert_active) || $past(reg_wr))
		else $error("ready request without cause");
	chk_read_clears: assert property (
		reg_rd && reg_addr == 5'h10 && !core_done |=> !result_ready_irq && !window_match_irq)
		else $error("result read left requests");
	chk_one_clears: assert property (
		reg_wr && reg_addr == 5'h0B && reg_wr_data[0] && !core_done |=> !result_ready_irq)
		else $error("flag write one kept request");
	chk_zero_keeps: assert property (
		reg_wr && reg_addr == 5'h0B && reg_wr_data[1:0] == 2'b00 && !core_done
		|=> $stable(result_ready_irq))
		else $error("flag write zero changed request");
	chk_select_hold: assert property (
		busy && $past(busy) && !$past(core_done) |-> $stable(input_select))
		else $error("select changed mid conversion");
endmodule
bind adcseq_regs adcseq_regs_monitor u_monitor (.sys_clk(sys_clk), .reset_n(reset_n),
	.reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.start_event(start_event), .debug_break(debug_break), .input_select(input_select),
	.sample_active(sample_active), .convert_active(convert_active), .core_done(core_done),
	.result_ready_irq(result_ready_irq), .window_match_irq(window_match_irq));
`default_nettype wire

/* File: adcseq_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module adcseq_core_model (
	// converter side
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	input  wire logic [4:0] input_select,
	input  wire logic       convert_active,
	output logic            core_done,
	output logic      [9:0] core_data,
	// stimulus knobs
	input  wire logic [9:0] level,
	input  wire logic [7:0] lag
);
	logic [7:0] cnt_q;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= 8'h00;
			core_done <= 1'b0;
			core_data <= 10'h000;
		end else begin
			core_done <= 1'b0;
			// no valid sample outside the done pulse
			core_data <= ~core_data;
			cnt_q <= (convert_active && !core_done) ? cnt_q + 8'h01 : 8'h00;
			if (convert_active && !core_done && cnt_q == lag) begin
				core_done <= 1'b1;
				core_data <= level + {5'h00, input_select};
			end
		end
	end
endmodule
`default_nettype wire

/* File: adcseq_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module adcseq_regs_tb;
	logic        sys_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic        start_event = 1'b0, debug_break = 1'b0, core_over = 1'b0, core_under = 1'b0;
	logic        core_done, sample_active, convert_active, result_ready_irq, window_match_irq;
	logic [4:0]  reg_addr = 5'h00, input_select;
	logic [7:0]  reg_wr_data = 8'h00, reg_rd_data, lag = 8'h04;
	logic [9:0]  core_data, level = 10'h105;
	logic [15:0] d, w, r;
	int          bad_count, total_checks, samp_n;
	logic [4:0]  ofs [10] = '{5'h06, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h10, 5'h12, 5'h1F};
	adcseq_regs uut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
		.start_event(start_event), .debug_break(debug_break), .input_select(input_select),
		.sample_active(sample_active), .convert_active(convert_active), .core_done(core_done),
		.core_data(core_data), .core_over(core_over), .core_under(core_under),
		.result_ready_irq(result_ready_irq), .window_match_irq(window_match_irq));
	adcseq_core_model core (.sys_clk(sys_clk), .reset_n(reset_n), .input_select(input_select),
		.convert_active(convert_active), .core_done(core_done), .core_data(core_data),
		.level(level), .lag(lag));
	always #12.5 sys_clk = ~sys_clk;
	always @(negedge sys_clk) if (sample_active) samp_n++;
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wr_data <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		// data stands for the whole cycle after the strobe; take it at that cycle's closing edge
		@(posedge sys_clk);
		v = {8'h00, reg_rd_data};
	endtask
	task automatic rd16(input logic [4:0] a, output logic [15:0] v);
		logic [15:0] h;
		rd(a, v);
		rd(a + 5'h01, h);
		v[15:8] = h[7:0];
	endtask
	task automatic wait_irq;
		int n;
		n = 0;
		// let a clear issued at the caller's edge settle before looking
		@(posedge sys_clk);
		while (result_ready_irq !== 1'b1) begin
			@(posedge sys_clk);
			n++;
			if (n > 3000) begin
				bad_count++;
				wrap_up;
			end
		end
	endtask
	task automatic conv;
		wr(5'h08, 8'h01);
		wait_irq;
	endtask
	task automatic ev;
		@(posedge sys_clk);
		start_event <= 1'b1;
		@(posedge sys_clk);
		start_event <= 1'b0;
	endtask
	function automatic logic win(input int m, input logic [15:0] v);
		case (m)
			1: win = v < 16'h0108;
			2: win = v > 16'h0300;
			3: win = v > 16'h0108 && v < 16'h0300;
			4: win = v < 16'h0108 || v > 16'h0300;
			default: win = 1'b0;
		endcase
	endfunction
	initial begin
		repeat (6) @(posedge sys_clk);
		reset_n <= 1'b1;
		foreach (ofs[i]) begin
			rd(ofs[i], d);
			chk(d, 16'h0000);
		end
		$display("test reset done");
		wr(5'h12, 8'h08);
		wr(5'h13, 8'h01);
		wr(5'h14, 8'h00);
		wr(5'h15, 8'h03);
		rd16(5'h12, w);
		chk(w, 16'h0108);
		rd(5'h0D, d);
		chk(d, 16'h0001);
		wr(5'h0D, 8'h5A);
		rd(5'h0D, d);
		chk(d, 16'h005A);
		$display("test staging done");
		wr(5'h0A, 8'h03);
		rd(5'h0A, d);
		chk(d, 16'h0003);
		wr(5'h06, 8'h05);
		wr(5'h05, 8'h03);
		samp_n = 0;
		wr(5'h08, 8'h01);
		rd(5'h08, d);
		chk(d, 16'h0001);
		wr(5'h06, 8'h07);
		wait_irq;
		chk(16'(samp_n), 16'h0005);
		rd(5'h08, d);
		chk(d, 16'h0000);
		rd(5'h0B, d);
		chk(d, 16'h0001);
		rd16(5'h10, w);
		chk(w, 16'h010A);
		rd(5'h0B, d);
		chk(d, 16'h0000);
		$display("test single done");
		wr(5'h05, 8'h00);
		for (int m = 0; m < 5; m++) begin
			for (int k = 0; k < 2; k++) begin
				core_over <= k[0];
				r = k[0] ? 16'h03FF : 16'h010C;
				wr(5'h04, 8'(m));
				conv;
				chk({15'h0000, window_match_irq}, {15'h0000, win(m, r)});
				rd16(5'h10, w);
				chk(w, r);
			end
		end
		$display("test window done");
		core_over <= 1'b1;
		for (int c = 0; c < 7; c++) begin
			wr(5'h01, 8'(c));
			conv;
			rd16(5'h10, w);
			chk(w, 16'(32'h3FF << c));
		end
		core_over <= 1'b0;
		core_under <= 1'b1;
		wr(5'h01, 8'h00);
		conv;
		rd16(5'h10, w);
		chk(w, 16'h0000);
		core_under <= 1'b0;
		$display("test accumulate done");
		wr(5'h08, 8'h01);
		wr(5'h08, 8'h00);
		#1 chk({14'h0000, sample_active, convert_active}, 16'h0000);
		repeat (20) @(posedge sys_clk);
		rd(5'h0B, d);
		chk(d, 16'h0000);
		$display("test abort done");
		ev;
		repeat (3) @(posedge sys_clk);
		#1 chk({15'h0000, sample_active}, 16'h0000);
		wr(5'h09, 8'h01);
		debug_break <= 1'b1;
		ev;
		repeat (3) @(posedge sys_clk);
		#1 chk({15'h0000, sample_active}, 16'h0000);
		wr(5'h0C, 8'h01);
		ev;
		rd(5'h08, d);
		chk(d, 16'h0001);
		wait_irq;
		wr(5'h0B, 8'h00);
		rd(5'h0B, d);
		chk(d, 16'h0001);
		wr(5'h0B, 8'h01);
		rd(5'h0B, d);
		chk(d, 16'h0000);
		debug_break <= 1'b0;
		$display("test event done");
		wr(5'h00, 8'h02);
		conv;
		wr(5'h0B, 8'h03);
		wait_irq;
		rd(5'h08, d);
		chk(d, 16'h0001);
		wr(5'h08, 8'h00);
		wr(5'h00, 8'h00);
		$display("test continuous done");
		wrap_up;
	end
endmodule
`default_nettype wire
